// file: scdram_defs.svh
// constants and timing figures for the static column dram host controller
`ifndef SCDRAM_DEFS_SVH
`define SCDRAM_DEFS_SVH
`define MCLK_PERIOD_NS 50
`define CEIL_CYC(ns) (((ns) + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define MIN_ROW_ACTIVE_NS 100
`define ROW_PRECHARGE_NS 100
`define ROW_ADDR_HOLD_NS 25
`define COLUMN_ADDR_HOLD_NS 30
`define ROW_ACCESS_DELAY_NS 100
`define COLUMN_ADDR_ACCESS_DELAY_NS 50
`define OUTPUT_ENABLE_ACCESS_DELAY_NS 30
`define COLUMN_STROBE_ACCESS_DELAY_NS 40
`define WRITE_PULSE_NS 50
`define PWRUP_US 100
`define REFRESH_MS 4
`define ROW_COUNT 256
`define INIT_CYCLES 4'h8
`define SYNC_DEPTH 3
`define RAS_MIN_CYC `CEIL_CYC(`MIN_ROW_ACTIVE_NS)
`define PRE_CYC `CEIL_CYC(`ROW_PRECHARGE_NS)
`define RAH_CYC `CEIL_CYC(`ROW_ADDR_HOLD_NS)
`define CAH_CYC `CEIL_CYC(`COLUMN_ADDR_HOLD_NS)
`define WP_CYC `CEIL_CYC(`WRITE_PULSE_NS)
`define PWRUP_CYC `CEIL_CYC(`PWRUP_US * 1000)
`define REF_INT_CYC ((`REFRESH_MS * 1000000) / `MCLK_PERIOD_NS / `ROW_COUNT)
`endif

// file: scdram_dev_model.sv
// behavioural model of the 64k x 4 static column dram seen by the host
`timescale 1ns/100ps
module scdram_dev_model #(
	parameter real ACC_NS = 100.0,
	parameter real ACT_NS = 100.0,
	parameter real PRE_NS = 100.0,
	parameter real REF_NS = 4.0e6
) (
	input wire logic ras_n, // row strobe
	input wire logic cas_n, // column strobe
	input wire logic we_n, // write enable
	input wire logic oe_n, // output enable
	input wire logic [7:0] addr, // multiplexed address
	input wire logic [3:0] dq_in, // level on the data wire
	output logic [3:0] dq_out, // data offered by the device
	output logic dq_drv, // device drives the data wire
	output logic [2:0] fault // short active, short precharge, late refresh
);
	// ***********
	// array and pins
	// ***********
	logic [3:0] mem [0:65535];
	logic [7:0] row;
	logic [3:0] flow, hold_q, last_q;
	logic held, t0;
	realtime fell_t, rose_t;
	realtime seen_t [0:255];
	initial
	begin
		fault = 3'h0;
		held = 1'b0;
		t0 = 1'b0;
		last_q = 4'h0;
		rose_t = -1.0e9;
	end
	// column path flows through, no column latch on reads
	assign #(ACC_NS) flow = mem[{row, addr}];
	assign dq_drv = !cas_n && we_n && !oe_n && (!ras_n || held);
	assign dq_out = dq_drv ? (ras_n ? hold_q : flow) : ~last_q;
	// a released wire shows the inverse of what the device last drove
	always @(dq_out or dq_drv)
		if (dq_drv && !$isunknown(dq_out))
			last_q = dq_out;
	always @(negedge ras_n)
	begin
		if ($realtime - rose_t < PRE_NS)
			fault[1] = 1'b1;
		fell_t = $realtime;
		#1;
		row = addr;
		if (!t0)
			foreach (seen_t[i])
				seen_t[i] = $realtime;
		t0 = 1'b1;
		if ($realtime - seen_t[row] > REF_NS)
			fault[2] = 1'b1;
		seen_t[row] = $realtime;
	end
	always @(posedge ras_n)
	begin
		if (t0 && $realtime - fell_t < ACT_NS)
			fault[0] = 1'b1;
		rose_t = $realtime;
	end
	always @(posedge ras_n or posedge cas_n or posedge oe_n)
	begin
		held = ras_n && !cas_n && !oe_n && we_n;
		hold_q = flow;
	end
	// write is self-timed: taken at the later falling strobe
	always @(negedge cas_n or negedge we_n)
	begin
		#1;
		if (!ras_n && !cas_n && !we_n)
			mem[{row, addr}] = dq_in;
	end
endmodule : scdram_dev_model

// file: scdram_host.sv
// host controller driving a 64k x 4 static column dram through its pins
`timescale 1ns/100ps
`include "scdram_defs.svh"
module scdram_host #(
	parameter int TIMER_W = 12
) (
	input wire logic mclk, // system clock
	input wire logic rst, // async reset, active high
	input wire logic req, // access request, level
	input wire logic req_write, // 1 write, 0 read
	input wire logic [15:0] req_addr, // word address, row in high byte
	input wire logic [3:0] req_wdata, // write data
	output logic ready, // request taken while high
	output logic [3:0] rdata, // read data
	output logic rvalid, // read data pulse
	output logic init_done, // power-on sequence finished
	output logic ras_n, // row strobe pin
	output logic cas_n, // column strobe pin
	output logic we_n, // write enable pin
	output logic oe_n, // output enable pin
	output logic [7:0] dram_addr, // multiplexed address pins
	output logic [3:0] dq_o, // data pin output
	output logic dq_oe, // data pin drive enable
	input wire logic [3:0] dq_i // data pin input
);
	// ****************************************
	// timing counts
	// ****************************************
	localparam logic [TIMER_W-1:0] RAS_MIN = TIMER_W'(`RAS_MIN_CYC);
	localparam logic [TIMER_W-1:0] PRE_MIN = TIMER_W'(`PRE_CYC);
	localparam logic [TIMER_W-1:0] RAH = TIMER_W'(`RAH_CYC);
	localparam logic [TIMER_W-1:0] CAH = TIMER_W'(`CAH_CYC);
	localparam logic [TIMER_W-1:0] WP = TIMER_W'(`WP_CYC);
	localparam logic [TIMER_W-1:0] PWRUP = TIMER_W'(`PWRUP_CYC);
	localparam logic [TIMER_W-1:0] REF_INT = TIMER_W'(`REF_INT_CYC);
	localparam int RD_NS = (`ROW_ACCESS_DELAY_NS > `COLUMN_ADDR_ACCESS_DELAY_NS) ? `ROW_ACCESS_DELAY_NS
		: `COLUMN_ADDR_ACCESS_DELAY_NS;
	localparam int RD2_NS = (`OUTPUT_ENABLE_ACCESS_DELAY_NS > `COLUMN_STROBE_ACCESS_DELAY_NS)
		? `OUTPUT_ENABLE_ACCESS_DELAY_NS : `COLUMN_STROBE_ACCESS_DELAY_NS;
	localparam logic [TIMER_W-1:0] RD_WAIT = TIMER_W'(`CEIL_CYC((RD_NS > RD2_NS) ? RD_NS : RD2_NS) + `SYNC_DEPTH);

	function automatic logic [7:0] row_of(input logic [15:0] a);
		row_of = a[15:8];
	endfunction : row_of

	function automatic logic [7:0] col_of(input logic [15:0] a);
		col_of = a[7:0];
	endfunction : col_of

	// ****************************************
	// state
	// ****************************************
	scdram_pkg::state_type state_reg, state_next;
	logic [TIMER_W-1:0] timer_reg, timer_next;
	logic [TIMER_W-1:0] ref_tmr_reg, ref_tmr_next;
	logic [TIMER_W-1:0] ras_cnt_reg, ras_cnt_next;
	logic ref_due_reg, ref_due_next;
	logic [7:0] ref_row_reg, ref_row_next;
	logic [3:0] init_cnt_reg, init_cnt_next;
	logic [15:0] op_addr_reg, op_addr_next;
	logic op_write_reg, op_write_next;
	logic [3:0] op_data_reg, op_data_next;
	logic pend_reg, pend_next;
	logic ready_reg, ready_next;
	logic [3:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic ras_n_reg, ras_n_next;
	logic cas_n_reg, cas_n_next;
	logic we_n_reg, we_n_next;
	logic oe_n_reg, oe_n_next;
	logic [7:0] addr_reg, addr_next;
	logic [3:0] dq_o_reg, dq_o_next;
	logic dq_oe_reg, dq_oe_next;
	logic init_done_reg, init_done_next;
	logic [3:0] sync1_reg, sync2_reg, sync3_reg;

	wire take = req & ready_reg;
	wire timer_zero = (timer_reg == '0);
	wire ras_met = (ras_cnt_reg >= RAS_MIN);
	wire ref_tick = (ref_tmr_reg == '0);
	wire sync_agree = (sync2_reg == sync3_reg);
	wire same_row = (row_of(req_addr) == row_of(op_addr_reg));
	wire in_init = (init_cnt_reg != `INIT_CYCLES);

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		state_next = state_reg;
		timer_next = timer_zero ? timer_reg : timer_reg - TIMER_W'(1);
		// reload one short: the zero state counts too, so the tick period equals the interval
		ref_tmr_next = ref_tick ? REF_INT - TIMER_W'(1) : ref_tmr_reg - TIMER_W'(1);
		ras_cnt_next = ras_n_reg ? '0 : (ras_met ? ras_cnt_reg : ras_cnt_reg + TIMER_W'(1));
		ref_due_next = ref_due_reg | ref_tick;
		ref_row_next = ref_row_reg;
		init_cnt_next = init_cnt_reg;
		op_addr_next = op_addr_reg;
		op_write_next = op_write_reg;
		op_data_next = op_data_reg;
		pend_next = pend_reg;
		ready_next = ready_reg;
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		ras_n_next = ras_n_reg;
		cas_n_next = cas_n_reg;
		we_n_next = we_n_reg;
		oe_n_next = oe_n_reg;
		addr_next = addr_reg;
		dq_o_next = dq_o_reg;
		dq_oe_next = dq_oe_reg;
		init_done_next = !in_init;
		if (take)
		begin
			op_addr_next = req_addr;
			op_write_next = req_write;
			op_data_next = req_wdata;
			ready_next = 1'b0;
		end
		case (state_reg)
			scdram_pkg::ST_PWRUP:
				if (timer_zero)
					state_next = scdram_pkg::ST_REF;
			scdram_pkg::ST_IDLE:
				if (ref_due_reg)
				begin
					// a request taken on this edge waits out the refresh
					pend_next = pend_reg | take;
					ready_next = 1'b0;
					state_next = scdram_pkg::ST_REF;
				end
				else if (take || pend_reg)
				begin
					ras_n_next = 1'b0;
					addr_next = take ? row_of(req_addr) : row_of(op_addr_reg);
					timer_next = RAH;
					pend_next = 1'b0;
					ready_next = 1'b0;
					state_next = scdram_pkg::ST_ROW;
				end
			scdram_pkg::ST_ROW, scdram_pkg::ST_OPEN:
				if (state_reg == scdram_pkg::ST_OPEN && !take)
					state_next = scdram_pkg::ST_CLOSE;
				else if (state_reg == scdram_pkg::ST_OPEN && (ref_due_reg || !same_row))
				begin
					// the request is already taken, so it is replayed once the row is closed
					pend_next = 1'b1;
					state_next = scdram_pkg::ST_CLOSE;
				end
				else if (state_reg == scdram_pkg::ST_OPEN || timer_zero)
				begin
					// column change on the open row, no new row strobe
					addr_next = col_of(take ? req_addr : op_addr_reg);
					cas_n_next = 1'b0;
					if (take ? req_write : op_write_reg)
					begin
						we_n_next = 1'b0;
						dq_o_next = take ? req_wdata : op_data_reg;
						dq_oe_next = 1'b1;
						timer_next = WP;
						state_next = scdram_pkg::ST_WRITE;
					end
					else
					begin
						oe_n_next = 1'b0;
						timer_next = RD_WAIT;
						state_next = scdram_pkg::ST_READ;
					end
				end
			scdram_pkg::ST_READ:
				if (timer_zero && sync_agree)
				begin
					rdata_next = sync3_reg;
					rvalid_next = 1'b1;
					cas_n_next = 1'b1;
					oe_n_next = 1'b1;
					timer_next = CAH;
					state_next = scdram_pkg::ST_HOLD;
				end
			scdram_pkg::ST_WRITE:
				if (timer_zero)
				begin
					// ending with the column strobe keeps the dram output off
					cas_n_next = 1'b1;
					timer_next = CAH;
					state_next = scdram_pkg::ST_HOLD;
				end
			scdram_pkg::ST_HOLD:
				if (timer_zero)
				begin
					we_n_next = 1'b1;
					dq_oe_next = 1'b0;
					ready_next = 1'b1;
					state_next = scdram_pkg::ST_OPEN;
				end
			scdram_pkg::ST_CLOSE:
			begin
				ready_next = 1'b0;
				pend_next = pend_reg | take;
				if (ras_met)
				begin
					ras_n_next = 1'b1;
					timer_next = PRE_MIN;
					state_next = scdram_pkg::ST_PRE;
				end
			end
			scdram_pkg::ST_REF:
				// row-only refresh; the counter steps once per cycle
				if (ras_n_reg)
				begin
					ras_n_next = 1'b0;
					addr_next = ref_row_reg;
					ref_due_next = ref_tick;
					if (in_init)
						init_cnt_next = init_cnt_reg + 4'h1;
				end
				else if (ras_met)
				begin
					ras_n_next = 1'b1;
					ref_row_next = ref_row_reg + 8'h01;
					timer_next = PRE_MIN;
					state_next = scdram_pkg::ST_PRE;
				end
			scdram_pkg::ST_PRE:
				if (timer_zero)
				begin
					if (in_init)
						state_next = scdram_pkg::ST_REF;
					else
					begin
						ready_next = !pend_reg;
						state_next = scdram_pkg::ST_IDLE;
					end
				end
			default:
				state_next = scdram_pkg::ST_IDLE;
		endcase
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= scdram_pkg::ST_PWRUP;
			timer_reg <= PWRUP;
			ref_tmr_reg <= REF_INT;
			ras_cnt_reg <= '0;
			ref_due_reg <= 1'b0;
			ref_row_reg <= 8'h00;
			init_cnt_reg <= 4'h0;
			op_addr_reg <= 16'h0000;
			op_write_reg <= 1'b0;
			op_data_reg <= 4'h0;
			pend_reg <= 1'b0;
			ready_reg <= 1'b0;
			rdata_reg <= 4'h0;
			rvalid_reg <= 1'b0;
			ras_n_reg <= 1'b1;
			cas_n_reg <= 1'b1;
			we_n_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			addr_reg <= 8'h00;
			dq_o_reg <= 4'h0;
			dq_oe_reg <= 1'b0;
			init_done_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			timer_reg <= timer_next;
			ref_tmr_reg <= ref_tmr_next;
			ras_cnt_reg <= ras_cnt_next;
			ref_due_reg <= ref_due_next;
			ref_row_reg <= ref_row_next;
			init_cnt_reg <= init_cnt_next;
			op_addr_reg <= op_addr_next;
			op_write_reg <= op_write_next;
			op_data_reg <= op_data_next;
			pend_reg <= pend_next;
			ready_reg <= ready_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
			ras_n_reg <= ras_n_next;
			cas_n_reg <= cas_n_next;
			we_n_reg <= we_n_next;
			oe_n_reg <= oe_n_next;
			addr_reg <= addr_next;
			dq_o_reg <= dq_o_next;
			dq_oe_reg <= dq_oe_next;
			init_done_reg <= init_done_next;
		end
	end

	// data pins come from outside the clock domain
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
			sync3_reg <= 4'h0;
		end
		else
		begin
			sync1_reg <= dq_i;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	assign ready = ready_reg;
	assign rdata = rdata_reg;
	assign rvalid = rvalid_reg;
	assign init_done = init_done_reg;
	assign ras_n = ras_n_reg;
	assign cas_n = cas_n_reg;
	assign we_n = we_n_reg;
	assign oe_n = oe_n_reg;
	assign dram_addr = addr_reg;
	assign dq_o = dq_o_reg;
	assign dq_oe = dq_oe_reg;

	// ****************************************
	// assertions
	// ****************************************
	logic [TIMER_W-1:0] hi_cnt_reg;
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			hi_cnt_reg <= '0;
		else if (!ras_n_reg)
			hi_cnt_reg <= '0;
		else if (hi_cnt_reg != PWRUP)
			hi_cnt_reg <= hi_cnt_reg + TIMER_W'(1);
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_ras_min_active: assert property ($rose(ras_n_reg) |-> $past(ras_cnt_reg) >= RAS_MIN)
		else $error("row strobe low shorter than minimum");
	a_ras_precharge: assert property ($fell(ras_n_reg) && init_cnt_reg > 4'h1 |-> $past(hi_cnt_reg) >= PRE_MIN)
		else $error("precharge too short");
	a_power_wait: assert property ($fell(ras_n_reg) && init_cnt_reg == 4'h1 |-> $past(hi_cnt_reg) >= PWRUP)
		else $error("power up wait too short");
	a_read_we_high: assert property (!oe_n_reg |-> we_n_reg && !ras_n_reg)
		else $error("write enable low during read");
	a_write_in_row: assert property ($fell(we_n_reg) |-> !ras_n_reg && $fell(cas_n_reg) && dq_oe_reg)
		else $error("write not inside row cycle");
	a_oe_off_write: assert property (!we_n_reg |-> oe_n_reg)
		else $error("output enable low during write");
	a_col_addr: assert property ($fell(cas_n_reg) |-> dram_addr == col_of(op_addr_reg))
		else $error("wrong column address");
	a_cas_row: assert property (!cas_n_reg |-> !ras_n_reg)
		else $error("column strobe low without row strobe");
	a_refresh_served: assert property ($rose(ref_due_reg) && !in_init |-> ##[1:64] state_reg == scdram_pkg::ST_REF)
		else $error("refresh not served in time");
	a_row_counter: assert property ($rose(ras_n_reg) && $past(state_reg) == scdram_pkg::ST_REF |->
		ref_row_reg == $past(ref_row_reg) + 8'h01)
		else $error("refresh row counter did not step");
	a_init_first: assert property ($fell(cas_n_reg) |-> init_cnt_reg == `INIT_CYCLES)
		else $error("access before init cycles");

	c_read: cover property (rvalid_reg);
	c_write: cover property ($rose(cas_n_reg) && !we_n_reg);
	c_refresh: cover property (state_reg == scdram_pkg::ST_REF && !in_init && $fell(ras_n_reg));
	c_static_col: cover property (state_reg == scdram_pkg::ST_OPEN && take && same_row && !ref_due_reg);
endmodule : scdram_host

// file: scdram_pkg.sv
// types of the static column dram host controller
package scdram_pkg;
	typedef enum logic [3:0] {ST_PWRUP, ST_IDLE, ST_ROW, ST_READ, ST_WRITE, ST_HOLD, ST_OPEN, ST_CLOSE, ST_REF,
		ST_PRE} state_type;
endpackage : scdram_pkg

// file: test_scdram_host.sv
// self-checking bench for the static column dram host controller
`timescale 1ns/100ps
module test_scdram_host;
	localparam int RUN_CYC = 85000;
	localparam int LIMIT_CYC = 95000;
	localparam logic [20:0] CORNER [9] = '{21'h10000A, 21'h100FF5, 21'h000000, 21'h000FF0, 21'h1FFFFF,
		21'h0FFFF0, 21'h000FF0, 21'h15A103, 21'h05A100};
	localparam logic [7:0] ROWS [4] = '{8'h00, 8'hFF, 8'h5A, 8'hA5};
	logic mclk = 1'b0; // set without an edge, so no monitor fires at time zero
	logic rst, req, req_write, ready, rvalid, init_done;
	logic ras_n, cas_n, we_n, oe_n, dq_oe, dq_drv, seen_ras, had_cas;
	logic [15:0] req_addr, pick_addr;
	logic [3:0] req_wdata, rdata, dq_o, dq_out, dq_i;
	logic [7:0] dram_addr, ref_row;
	logic [2:0] fault;
	logic [31:0] rnd;
	logic [3:0] shadow [0:65535];
	logic written [0:65535];
	int errors, tests_run, cycles, ras_falls, cas_falls;
	realtime rel_t;
	assign dq_i = dq_oe ? dq_o : dq_out;
	scdram_host u_dut (.mclk(mclk), .rst(rst), .req(req), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .ready(ready), .rdata(rdata), .rvalid(rvalid), .init_done(init_done),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .dram_addr(dram_addr), .dq_o(dq_o),
		.dq_oe(dq_oe), .dq_i(dq_i));
	scdram_dev_model u_mem (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .addr(dram_addr),
		.dq_in(dq_i), .dq_out(dq_out), .dq_drv(dq_drv), .fault(fault));
	// ***********
	// helpers
	// ***********
	task automatic check(input logic ok, input string msg);
		tests_run++;
		if (!ok)
		begin
			errors++;
			$display("unexpected at %0t: %s", $realtime, msg);
		end
	endtask : check
	function automatic logic [31:0] xorshift_next(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xorshift_next
	function automatic logic [3:0] expect_rd(input logic [15:0] a);
		return shadow[a];
	endfunction : expect_rd
	task automatic access(input logic wr, input logic [15:0] a, input logic [3:0] d);
		int k = 0;
		int j = 0;
		@(negedge mclk);
		req = 1'b1;
		req_write = wr;
		req_addr = a;
		req_wdata = d;
		@(posedge mclk);
		while (ready !== 1'b1 && k < 3000)
		begin
			k++;
			@(posedge mclk);
		end
		@(negedge mclk);
		req = 1'b0;
		check(k < 3000, "request never taken");
		if (wr)
		begin
			shadow[a] = d;
			written[a] = 1'b1;
		end
		else
		begin
			while (rvalid !== 1'b1 && j < 40)
			begin
				j++;
				@(negedge mclk);
			end
			check(rvalid === 1'b1, "no read data pulse");
			check(rdata === expect_rd(a), "read data differs");
		end
	endtask : access
	task complete_run;
		if (errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run
	// ***********
	// clock, monitors and sequence
	// ***********
	initial
	begin
		forever #25 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles >= LIMIT_CYC)
		begin
			errors++;
			$display("unexpected at %0t: run hung", $realtime);
			complete_run();
		end
	end
	always @(negedge mclk)
	begin
		if (!seen_ras)
			check(ras_n === 1'b1 && cas_n === 1'b1, "strobes low at power up");
		if (we_n === 1'b0)
			check(ras_n === 1'b0 && oe_n === 1'b1 && dq_oe === 1'b1, "write pins");
		if (oe_n === 1'b0)
			check(we_n === 1'b1 && ras_n === 1'b0, "read pins");
		if (cas_n === 1'b0)
			check(ras_n === 1'b0, "column strobe outside a row cycle");
		check(!(dq_oe === 1'b1 && dq_drv === 1'b1), "data wire contention");
	end
	always @(negedge ras_n)
	begin
		if (!seen_ras)
			check($realtime - rel_t >= 100000.0, "power up pause short");
		seen_ras = 1'b1;
		ras_falls++;
	end
	always @(negedge cas_n)
	begin
		if (cas_falls == 0)
			check(ras_falls >= 9 && init_done === 1'b1, "too few start cycles");
		cas_falls++;
		had_cas = 1'b1;
	end
	// a row cycle with no column strobe is a refresh; rows must step by one
	always @(posedge ras_n)
	begin
		if (!had_cas && seen_ras)
		begin
			if (ras_falls > 1)
				check(u_mem.row === ref_row + 8'h01, "refresh row order");
			ref_row = u_mem.row;
		end
		had_cas = 1'b0;
	end
	initial
	begin
		rst = 1'b1;
		req = 1'b0;
		req_write = 1'b0;
		req_addr = 16'h0000;
		req_wdata = 4'h0;
		errors = 0;
		tests_run = 0;
		cycles = 0;
		ras_falls = 0;
		cas_falls = 0;
		seen_ras = 1'b0;
		had_cas = 1'b0;
		foreach (written[i])
			written[i] = 1'b0;
		rnd = 32'h0000005F;
		repeat (5) @(negedge mclk);
		rst = 1'b0;
		rel_t = $realtime;
		foreach (CORNER[i])
			access(CORNER[i][20], CORNER[i][19:4], CORNER[i][3:0]);
		// few rows so that open-row hits and row changes both occur often
		while (cycles < RUN_CYC)
		begin
			rnd = xorshift_next(rnd);
			pick_addr = {ROWS[rnd[1:0]], rnd[15] ? 4'hF : 4'h0, rnd[11:8]};
			access(rnd[4] || !written[pick_addr], pick_addr, rnd[23:20]);
		end
		foreach (u_mem.seen_t[i])
			check($realtime - u_mem.seen_t[i] <= 4.0e6, "row left unrefreshed");
		check(fault === 3'h0, "row strobe timing broken");
		complete_run();
	end
endmodule : test_scdram_host
